// File: logic/pums_regs.svh
// Offsets, field positions, fixed addresses, vectors and timing counts of the start-up
// sequencer. Assumes inclusion by its bare name from the sequencer module.
`ifndef PUMS_REGS_SVH
`define PUMS_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define PUMS_CTRL_ADDR       12'h000
`define PUMS_STATUS_ADDR     12'h004
`define PUMS_PC_ADDR         12'h008
`define PUMS_PSW_ADDR        12'h00C
`define PUMS_MEMDATA_ADDR    12'h010
`define PUMS_UADDR_ADDR      12'h014
`define PUMS_VECTOR_ADDR     12'h018

// ****************************************************************
// Fixed addresses and vectors (octal values written in hex)
// ****************************************************************
`define PUMS_PC_LOC          16'h0014
`define PUMS_PSW_LOC         16'h0016
`define PUMS_BOOT_ADDR       16'hF600
`define PUMS_CONSOLE_ADDR    16'hFF70
`define PUMS_VEC_TIMEOUT     16'h0004
`define PUMS_VEC_RESERVED    16'h0008
`define PUMS_VEC_EVENT       16'h0040
`define PUMS_UADDR_EXP       12'h602
`define PUMS_UADDR_TRAP      12'h000
`define PUMS_PSW_TRACE_BIT   4
`define PUMS_PSW_IDIS_BIT    7

// ****************************************************************
// Timing
// ****************************************************************
`define PUMS_CLK_PERIOD_PS   5000
`define PUMS_PHASE_NS        95
`define PUMS_PHASE_CYCLES \
  ((`PUMS_PHASE_NS * 1000 + `PUMS_CLK_PERIOD_PS - 1) / `PUMS_CLK_PERIOD_PS)
`define PUMS_EVENT_TYP_US    16
`define PUMS_EVENT_MAX_NS    44100
`define PUMS_EVENT_MAX_CYCLES \
  ((`PUMS_EVENT_MAX_NS * 1000) / `PUMS_CLK_PERIOD_PS)
`define PUMS_TIMEOUT_CYCLES  64

`endif

// File: logic/pums_pkg.sv
// Types shared by the start-up sequencer.
// Uses nothing from the register header.
package pums_pkg;

  typedef enum logic [3:0] {
    PUMS_ST_RESET   = 4'b0000,
    PUMS_ST_SELECT  = 4'b0001,
    PUMS_ST_RD_PC   = 4'b0010,
    PUMS_ST_RD_PSW  = 4'b0011,
    PUMS_ST_HALTCHK = 4'b0100,
    PUMS_ST_BOOT    = 4'b0101,
    PUMS_ST_EXPAND  = 4'b0110,
    PUMS_ST_CONSOLE = 4'b0111,
    PUMS_ST_RUN     = 4'b1000,
    PUMS_ST_TRAP    = 4'b1001
  } pums_state_type;

  typedef struct packed {
    logic        req;
    logic [15:0] addr;
  } pums_memreq_type;

  typedef struct packed {
    logic        init_active;
    logic        dma_grant_cycle;
  } pums_inhibit_type;

endpackage : pums_pkg

// File: logic/pums_sequencer.sv
// Power-up mode sequencer with event interrupt and bus driver gating.
// Assumes an APB master on sys_clk and a memory port that answers reads.
`timescale 1ns/1ps
`default_nettype none
`include "pums_regs.svh"

// Behaviour
// - Mode 0 loads PC, PSW from 24, 26.
// - Mode 0 then halt low gives console.
// - Trace bit taken from word at 26.
// - Mode 1 enters console regardless of halt.
// - Mode 2 loads 173000 into PC, runs.
// - Mode 2 clears trace, sets interrupt disable.
// - Mode 2 with halt goes to console.
// - No answer at boot traps via 4.
// - Mode 3 jumps to microaddress 3002.
// - No ROM answer: microtrap, vector 10.
// - Mode 3 ignores the halt line; RUN still turns halt low into console.
// - Events only while running, jumper absent.
// - Event ranks above external requests.
// - Event sets interrupt disable, vectors 100.
// - Event served within bounded latency; code only counts it, saturating at 8820.
// - Timing from four 95 ns phases.
// - Driver group needs both enables low.
// - Init or DMA grant inhibit drivers.
// - Shared 22-bit microinstruction bus.
// - Mode from two jumpers, installed is one.
module pums_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        dc_power_good,
  input  wire logic        ac_power_good,
  input  wire logic        start_select_low_jumper,
  input  wire logic        start_select_high_jumper,
  input  wire logic        event_disable_jumper,
  input  wire logic        halt_request_line_n,
  input  wire logic        external_event_line_n,
  input  wire logic        external_irq_n,
  input  wire logic        internal_irq,
  input  wire logic        dma_grant_cycle,
  input  wire logic        microcode_rom_ack,
  output logic             mem_rd_req,
  output logic      [15:0] mem_addr,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata,
  output logic      [21:0] micro_bus,
  output logic      [3:0]  clk_phase,
  output logic             driver_enable_n,
  output logic             running,
  output logic             console_mode,
  output logic             event_irq_taken,
  output logic             ext_irq_taken
);

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int NSYNC = 9;
  // Active-low lines start at their idle level so no false request follows.
  localparam logic [NSYNC-1:0] SYNC_IDLE = 9'h00E;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] s1_q;
  logic [NSYNC-1:0] s2_q;
  logic [NSYNC-1:0] s3_q;
  logic [NSYNC-1:0] flt_q;

  assign raw_in = {dc_power_good, ac_power_good, start_select_low_jumper,
                   start_select_high_jumper, event_disable_jumper,
                   halt_request_line_n, external_event_line_n,
                   external_irq_n, dma_grant_cycle};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_q[gi]  <= SYNC_IDLE[gi];
          s2_q[gi]  <= SYNC_IDLE[gi];
          s3_q[gi]  <= SYNC_IDLE[gi];
          flt_q[gi] <= SYNC_IDLE[gi];
        end else begin
          s1_q[gi] <= raw_in[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi]) begin
            flt_q[gi] <= s3_q[gi];
          end
        end
      end
    end
  endgenerate

  logic dcok, acok, jmp_lo, jmp_hi, evdis, halt_n, event_n, xirq_n, dmagc;
  assign {dcok, acok, jmp_lo, jmp_hi, evdis, halt_n, event_n, xirq_n,
          dmagc} = flt_q;

  // ****************************************************************
  // Four-phase clock
  // ****************************************************************
  localparam logic [4:0] PH_LAST = 5'(`PUMS_PHASE_CYCLES - 1);
  logic [4:0] ph_cnt_q;
  logic [3:0] phase_q;
  logic       cycle_end;

  assign cycle_end = (ph_cnt_q == PH_LAST) && phase_q[3];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_cnt_q <= 5'h0;
      phase_q  <= 4'h1;
    end else if (ph_cnt_q == PH_LAST) begin
      ph_cnt_q <= 5'h0;
      phase_q  <= {phase_q[2:0], phase_q[3]};
    end else begin
      ph_cnt_q <= ph_cnt_q + 5'h1;
    end
  end

  // ****************************************************************
  // Start-up state machine
  // ****************************************************************
  pums_pkg::pums_state_type state_q;
  logic [15:0] pc_q, psw_q, vector_q;
  logic [11:0] uaddr_q;
  logic [1:0]  mode_q;
  logic [7:0]  tmo_q;
  logic        rd_q;
  logic [15:0] rd_addr_q;
  logic        init_q;
  logic        halt_soft_q, go_soft_q;
  logic [15:0] lat_q;
  logic        lat_on_q;

  function automatic logic tmo_hit(input logic [7:0] c);
    return c == 8'(`PUMS_TIMEOUT_CYCLES);
  endfunction : tmo_hit

  // Outside interrupts are open while the disable bit of the status is 0.
  function automatic logic irq_open(input logic [15:0] w);
    return !w[`PUMS_PSW_IDIS_BIT];
  endfunction : irq_open

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= pums_pkg::PUMS_ST_RESET;
      pc_q      <= 16'h0000;
      psw_q     <= 16'h0000;
      vector_q  <= 16'h0000;
      uaddr_q   <= 12'h000;
      mode_q    <= 2'b00;
      tmo_q     <= 8'h00;
      rd_q      <= 1'b0;
      rd_addr_q <= 16'h0000;
      init_q    <= 1'b1;
      event_irq_taken <= 1'b0;
      ext_irq_taken   <= 1'b0;
    end else begin
      event_irq_taken <= 1'b0;
      ext_irq_taken   <= 1'b0;
      case (state_q)
        pums_pkg::PUMS_ST_RESET: begin
          init_q <= 1'b1;
          if (dcok && acok && cycle_end) begin
            init_q  <= 1'b0;
            mode_q  <= {jmp_hi, jmp_lo};
            state_q <= pums_pkg::PUMS_ST_SELECT;
          end
        end
        pums_pkg::PUMS_ST_SELECT: begin
          tmo_q <= 8'h00;
          case (mode_q)
            2'b00: begin
              rd_q      <= 1'b1;
              rd_addr_q <= `PUMS_PC_LOC;
              state_q   <= pums_pkg::PUMS_ST_RD_PC;
            end
            2'b01: begin
              pc_q    <= `PUMS_CONSOLE_ADDR;
              state_q <= pums_pkg::PUMS_ST_CONSOLE;
            end
            2'b10: begin
              psw_q[`PUMS_PSW_TRACE_BIT] <= 1'b0;
              psw_q[`PUMS_PSW_IDIS_BIT]  <= 1'b1;
              pc_q      <= `PUMS_BOOT_ADDR;
              state_q   <= pums_pkg::PUMS_ST_BOOT;
            end
            default: begin
              uaddr_q <= `PUMS_UADDR_EXP;
              state_q <= pums_pkg::PUMS_ST_EXPAND;
            end
          endcase
        end
        pums_pkg::PUMS_ST_RD_PC: begin
          if (mem_ack) begin
            pc_q      <= mem_rdata;
            rd_addr_q <= `PUMS_PSW_LOC;
            state_q   <= pums_pkg::PUMS_ST_RD_PSW;
          end
        end
        pums_pkg::PUMS_ST_RD_PSW: begin
          if (mem_ack) begin
            psw_q   <= mem_rdata;
            rd_q    <= 1'b0;
            state_q <= pums_pkg::PUMS_ST_HALTCHK;
          end
        end
        pums_pkg::PUMS_ST_HALTCHK: begin
          state_q <= halt_n ? pums_pkg::PUMS_ST_RUN
                            : pums_pkg::PUMS_ST_CONSOLE;
        end
        pums_pkg::PUMS_ST_BOOT: begin
          if (!halt_n) begin
            state_q <= pums_pkg::PUMS_ST_CONSOLE;
          end else begin
            rd_q      <= 1'b1;
            rd_addr_q <= `PUMS_BOOT_ADDR;
            tmo_q     <= tmo_q + 8'h01;
            if (mem_ack) begin
              rd_q    <= 1'b0;
              state_q <= pums_pkg::PUMS_ST_RUN;
            end else if (tmo_hit(tmo_q)) begin
              rd_q     <= 1'b0;
              vector_q <= `PUMS_VEC_TIMEOUT;
              state_q  <= pums_pkg::PUMS_ST_TRAP;
            end
          end
        end
        pums_pkg::PUMS_ST_EXPAND: begin
          tmo_q <= tmo_q + 8'h01;
          if (microcode_rom_ack) begin
            state_q <= pums_pkg::PUMS_ST_RUN;
          end else if (tmo_hit(tmo_q)) begin
            uaddr_q  <= `PUMS_UADDR_TRAP;
            vector_q <= `PUMS_VEC_RESERVED;
            state_q  <= pums_pkg::PUMS_ST_TRAP;
          end
        end
        pums_pkg::PUMS_ST_TRAP: begin
          state_q <= pums_pkg::PUMS_ST_RUN;
        end
        pums_pkg::PUMS_ST_CONSOLE: begin
          if (go_soft_q) begin
            state_q <= pums_pkg::PUMS_ST_RUN;
          end
        end
        pums_pkg::PUMS_ST_RUN: begin
          if (halt_soft_q || !halt_n) begin
            state_q <= pums_pkg::PUMS_ST_CONSOLE;
          end else if (internal_irq) begin
            state_q <= pums_pkg::PUMS_ST_RUN;
          end else if (!event_n && !evdis
                       && irq_open(psw_q)) begin
            vector_q        <= `PUMS_VEC_EVENT;
            psw_q[`PUMS_PSW_IDIS_BIT] <= 1'b1;
            event_irq_taken <= 1'b1;
          end else if (!xirq_n && irq_open(psw_q)) begin
            ext_irq_taken <= 1'b1;
          end
        end
        default: begin
          state_q <= pums_pkg::PUMS_ST_RESET;
        end
      endcase
      if (!dcok) begin
        state_q <= pums_pkg::PUMS_ST_RESET;
        init_q  <= 1'b1;
      end
    end
  end

  // Latency counter from event assertion to vector taken.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q    <= 16'h0000;
      lat_on_q <= 1'b0;
    end else if (event_irq_taken || event_n) begin
      lat_q    <= 16'h0000;
      lat_on_q <= 1'b0;
    end else begin
      lat_on_q <= 1'b1;
      if (lat_q != 16'(`PUMS_EVENT_MAX_CYCLES)) begin
        lat_q <= lat_q + 16'h0001;
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      micro_bus       <= 22'h00_0000;
      clk_phase       <= 4'h0;
      driver_enable_n <= 1'b1;
      running         <= 1'b0;
      console_mode    <= 1'b0;
    end else begin
      micro_bus       <= {phase_q, 6'h00, uaddr_q};
      clk_phase       <= phase_q;
      driver_enable_n <= init_q | dmagc;
      running         <= state_q == pums_pkg::PUMS_ST_RUN;
      console_mode    <= state_q == pums_pkg::PUMS_ST_CONSOLE;
    end
  end

  // ****************************************************************
  // Memory port
  // ****************************************************************
  // The request flip-flops drive the pins so a new address shows at once.
  assign mem_rd_req = rd_q;
  assign mem_addr   = rd_addr_q;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  logic access;
  assign access = psel && penable;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      halt_soft_q <= 1'b0;
      go_soft_q   <= 1'b0;
    end else begin
      go_soft_q <= 1'b0;
      if (access && pwrite && paddr == `PUMS_CTRL_ADDR) begin
        halt_soft_q <= pwdata[0];
        go_soft_q   <= pwdata[1];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel && !penable) begin
        if (paddr == `PUMS_CTRL_ADDR) begin
          prdata <= {30'h0, 1'b0, halt_soft_q};
        end else if (paddr == `PUMS_STATUS_ADDR) begin
          prdata <= {16'h0, lat_q[7:0], lat_on_q, evdis, mode_q, state_q};
        end else if (paddr == `PUMS_PC_ADDR) begin
          prdata <= {16'h0, pc_q};
        end else if (paddr == `PUMS_PSW_ADDR) begin
          prdata <= {16'h0, psw_q};
        end else if (paddr == `PUMS_MEMDATA_ADDR) begin
          prdata <= {16'h0, rd_addr_q};
        end else if (paddr == `PUMS_UADDR_ADDR) begin
          prdata <= {20'h0, uaddr_q};
        end else if (paddr == `PUMS_VECTOR_ADDR) begin
          prdata <= {16'h0, vector_q};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

endmodule : pums_sequencer
`default_nettype wire

// File: sim/pums_assertions.sv
// Port checker for the start-up sequencer.
// Assumes it is bound to pums_sequencer on one clock domain.
`timescale 1ns/1ps
`default_nettype none
module pums_assertions (
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        event_disable_jumper,
  input wire logic        internal_irq,
  input wire logic        dma_grant_cycle,
  input wire logic        mem_rd_req,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic [21:0] micro_bus,
  input wire logic [3:0]  clk_phase,
  input wire logic        driver_enable_n,
  input wire logic        running,
  input wire logic        console_mode,
  input wire logic        event_irq_taken,
  input wire logic        ext_irq_taken
);
  logic [3:0] ph_prev_q;
  logic [7:0] ph_cnt_q;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Counts the cycles for which one clock phase has stood.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_prev_q <= 4'h0;
      ph_cnt_q  <= 8'h00;
    end else begin
      ph_prev_q <= clk_phase;
      ph_cnt_q  <= (clk_phase != ph_prev_q) ? 8'h00 : ph_cnt_q + 8'h01;
    end
  end

  chk_phase_onehot: assert property (
    clk_phase != 4'h0 |-> $onehot(clk_phase)) else $error("phase bad");
  chk_phase_len: assert property (
    (clk_phase != ph_prev_q && ph_prev_q != 4'h0) |-> ph_cnt_q == 8'h12)
    else $error("phase length");
  chk_drv_inhibit: assert property (
    dma_grant_cycle [*6] |-> driver_enable_n) else $error("driver on");
  chk_apb_answer: assert property (
    psel && !penable |=> pready) else $error("no ready");
  chk_mode0_order: assert property (
    mem_rd_req && mem_ack && mem_addr == 16'h0014
    |=> ##[0:8] mem_rd_req && mem_addr == 16'h0016) else $error("order");
  chk_event_gate: assert property (
    event_irq_taken |-> running && !event_disable_jumper)
    else $error("event gate");
  chk_event_rank: assert property (
    event_irq_taken |-> !$past(internal_irq) && !ext_irq_taken)
    else $error("event rank");
  chk_console_run: assert property (
    console_mode |-> !running) else $error("console and run");
  chk_ubus_fields: assert property (
    micro_bus[17:12] == 6'h00) else $error("micro bus field");

  cover property (event_irq_taken);
  cover property (console_mode);
  cover property (pslverr && pready);
endmodule : pums_assertions

bind pums_sequencer pums_assertions u_chk (.sys_clk, .rst_n, .psel,
  .penable, .pready, .pslverr, .event_disable_jumper, .internal_irq,
  .dma_grant_cycle, .mem_rd_req, .mem_addr, .mem_ack, .micro_bus,
  .clk_phase, .driver_enable_n, .running, .console_mode,
  .event_irq_taken, .ext_irq_taken);
`default_nettype wire

// File: sim/pums_mem_model.sv
// Memory model that answers the sequencer's word reads.
// Assumes a read is held until it is answered.
`timescale 1ns/1ps
`default_nettype none
module pums_mem_model (
  input  wire logic        sys_clk,
  input  wire logic        mem_rd_req,
  input  wire logic [15:0] mem_addr,
  input  wire logic        boot_present,
  input  wire logic        slow,
  input  wire logic [15:0] pc_word,
  input  wire logic [15:0] psw_word,
  output logic             mem_ack,
  output logic      [15:0] mem_rdata
);
  logic [2:0] wait_q = 3'h0;
  logic       hit;

  assign hit = (mem_addr != 16'hF600) || boot_present;

  initial begin
    mem_ack   = 1'b0;
    mem_rdata = 16'h0000;
  end

  // Answers after zero or four waits; data toggles when not answering.
  always @(posedge sys_clk) begin
    mem_ack   <= 1'b0;
    mem_rdata <= ~mem_rdata;
    wait_q    <= mem_rd_req ? wait_q + 3'h1 : 3'h0;
    if (mem_rd_req && hit && !mem_ack && wait_q >= (slow ? 3'h4 : 3'h0)) begin
      mem_ack   <= 1'b1;
      mem_rdata <= (mem_addr == 16'h0014) ? pc_word :
                   (mem_addr == 16'h0016) ? psw_word : 16'h0137;
      wait_q    <= 3'h0;
    end
  end
endmodule : pums_mem_model
`default_nettype wire

// File: sim/testbench.sv
// Self-checking bench for the start-up sequencer.
// Assumes the checker and the memory model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        sys_clk, rst_n, psel, penable, pwrite, pg, jlo, jhi, evdis;
  logic        halt_n, ev_n, xirq_n, iirq, dma, rom_ack, boot_ok, slow;
  logic        pready, pslverr, perr, mem_rd_req, mem_ack, running, run0;
  logic        driver_enable_n, console_mode, event_irq_taken, ext_irq_taken;
  logic [11:0] paddr;
  logic [15:0] mem_addr, mem_rdata;
  logic [31:0] pwdata, prdata, rd;
  int          errors, checks, ev_cnt, x_cnt, i;

  pums_sequencer u_dut (.sys_clk, .rst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .dc_power_good(pg),
    .ac_power_good(pg), .start_select_low_jumper(jlo),
    .start_select_high_jumper(jhi), .event_disable_jumper(evdis),
    .halt_request_line_n(halt_n), .external_event_line_n(ev_n),
    .external_irq_n(xirq_n), .internal_irq(iirq), .dma_grant_cycle(dma),
    .microcode_rom_ack(rom_ack), .mem_rd_req, .mem_addr, .mem_ack,
    .mem_rdata, .micro_bus(), .clk_phase(), .driver_enable_n, .running,
    .console_mode, .event_irq_taken, .ext_irq_taken);

  pums_mem_model u_mem (.sys_clk, .mem_rd_req, .mem_addr, .mem_ack,
    .boot_present(boot_ok), .slow, .pc_word(16'h0400),
    .psw_word(16'h0010), .mem_rdata);

  always #2.5 sys_clk = ~sys_clk;

  // Counts events, and outside requests served before any event.
  always @(posedge sys_clk) begin
    if (event_irq_taken === 1'b1) ev_cnt++;
    if (ext_irq_taken === 1'b1 && ev_cnt == 0) x_cnt++;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      $display("BAD %0t no ready", $time);
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  task automatic power_up(input logic [1:0] m, input logic h_n);
    rst_n <= 1'b0;
    pg <= 1'b0;
    {jhi, jlo} <= m;
    halt_n <= h_n;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge sys_clk);
    pg <= 1'b1;
    for (i = 0; i < 3000 && !(running | console_mode); i++)
      @(posedge sys_clk);
    run0 = running;
    repeat (4) @(posedge sys_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[5:4], m);
  endtask : power_up

  task automatic wait_ev(input int lim);
    for (i = 0; i < lim && ev_cnt == 0 && x_cnt == 0; i++)
      @(posedge sys_clk);
  endtask : wait_ev

  task automatic tally_and_finish();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  initial begin
    #400000;
    errors++;
    tally_and_finish();
  end

  initial begin
    {sys_clk, rst_n, psel, penable, pwrite, pg, jlo, jhi, evdis} = '0;
    {halt_n, ev_n, xirq_n, iirq, dma, rom_ack, boot_ok} = 7'h7F;
    {paddr, pwdata, slow, iirq, dma, rom_ack} = '0;
    {errors, checks, ev_cnt, x_cnt} = '0;
    slow <= 1'b1;
    power_up(2'h0, 1'b1);
    chk(running, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[15:0], 16'h0400);
    apb(1'b0, 12'h00C, 32'h0);
    chk(rd[4], 1'b1);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b0, 12'h100, 32'h0);
    chk(perr, 1'b1);
    {ev_n, evdis} <= 2'h1;
    wait_ev(300);
    chk(ev_cnt, 0);
    {iirq, evdis} <= 2'h2;
    wait_ev(100);
    chk(ev_cnt, 0);
    iirq <= 1'b0;
    wait_ev(8820);
    chk(ev_cnt > 0, 1'b1);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd[15:0], 16'h0040);
    chk(driver_enable_n, 1'b0);
    dma <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk(driver_enable_n, 1'b1);
    {ev_n, dma} <= 2'h2;
    power_up(2'h0, 1'b1);
    ev_cnt = 0;
    {ev_n, xirq_n} <= 2'h0;
    wait_ev(8820);
    chk(x_cnt, 0);
    chk(ev_cnt > 0, 1'b1);
    {ev_n, xirq_n} <= 2'h3;
    $display("mode 0 run test done");
    slow <= 1'b0;
    power_up(2'h0, 1'b0);
    chk(console_mode, 1'b1);
    power_up(2'h1, 1'b1);
    chk(console_mode, 1'b1);
    $display("console tests done");
    power_up(2'h2, 1'b1);
    chk(running, 1'b1);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd[15:0], 16'hF600);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[7], rd[4]}, 2'h2);
    power_up(2'h2, 1'b0);
    chk(console_mode, 1'b1);
    boot_ok <= 1'b0;
    power_up(2'h2, 1'b1);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd[15:0], 16'h0004);
    $display("mode 2 tests done");
    rom_ack <= 1'b1;
    power_up(2'h3, 1'b0);
    apb(1'b0, 12'h014, 32'h0);
    chk(rd[11:0], 12'h602);
    chk(run0, 1'b1);
    rom_ack <= 1'b0;
    power_up(2'h3, 1'b1);
    apb(1'b0, 12'h018, 32'h0);
    chk(rd[15:0], 16'h0008);
    $display("mode 3 tests done");
    tally_and_finish();
  end
endmodule : testbench
`default_nettype wire
